// file: hw/dma_channel_addr_irq.sv
// One DMA channel: memory address generation and block interrupt
`timescale 1ns/1ps
module dma_channel_addr_irq (
	// Clock and reset
	input logic core_clk,
	input logic rst,
	// Channel control register
	input logic ctrlWrite,
	input dma_chan_pkg::ctrl_type ctrlIn,
	output dma_chan_pkg::ctrl_type ctrlOut,
	// Block setup
	input logic [dma_chan_pkg::CNT_W-1:0] transferCount,
	input logic [dma_chan_pkg::ADDR_W-1:0] startAddressA,
	input logic [dma_chan_pkg::ADDR_W-1:0] startAddressB,
	output logic [dma_chan_pkg::ADDR_W-1:0] latestAddress,
	// Channel status
	output logic channelBusy,
	output logic activeBufferB,
	// Interrupt flag and request
	input logic flagClear,
	input logic channelIrqEnable,
	output logic irqFlag,
	output logic irqRequest,
	// Peripheral data stream
	input logic periphValid,
	input logic [dma_chan_pkg::DATA_W-1:0] periphData,
	output logic periphReady,
	// Dual port RAM write port
	output logic ramValid,
	input logic ramReady,
	output dma_chan_pkg::ram_req_type ramReq
);
	import dma_chan_pkg::*;

	// ********************************************************
	// Declarations
	// ********************************************************
	ctrl_type ctrl_r;
	chan_state_type state_r;
	logic [ADDR_W-1:0] workAddr_r;
	logic [ADDR_W-1:0] lastAddr_r;
	logic [DONE_W-1:0] doneCnt_r;
	logic needLoad_r;
	logic bufB_r;
	logic flag_r;
	logic wrSeen_r;
	logic bufValid;
	logic bufReady;
	logic [DATA_W-1:0] bufData;
	logic xfer;
	logic active;
	logic [DONE_W-1:0] doneNxt;
	logic [DONE_W-1:0] blockLen;
	logic [DONE_W-1:0] halfPoint;
	logic lastXfer;
	logic halfHit;
	logic irqEvent;
	logic pingPong;
	logic oneShot;
	logic [ADDR_W-1:0] startSel;
	logic [ADDR_W-1:0] curAddr;
	logic [ADDR_W-1:0] step;

	// ********************************************************
	// Control register
	// ********************************************************
	// Reset value selects post-increment addressing
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ctrl_r <= CTRL_RESET;
		end else if (ctrlWrite) begin
			ctrl_r <= ctrlIn;
		end
	end

	// Remembers whether software has written the control register
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wrSeen_r <= 1'b0;
		end else if (ctrlWrite) begin
			wrSeen_r <= 1'b1;
		end
	end

	assign ctrlOut = ctrl_r;
	assign pingPong = ctrl_r.opMode[MODE_PINGPONG_BIT];
	assign oneShot = ctrl_r.opMode[MODE_ONESHOT_BIT];

	// ********************************************************
	// Data buffer
	// ********************************************************
	// A RAM stall fills the buffer and then stalls the peripheral
	two_entry_buffer #(
		.WIDTH(DATA_W),
		.DEPTH(BUF_DEPTH)
	) two_entry_buffer_inst (
		.core_clk(core_clk),
		.rst(rst),
		.inValid(periphValid),
		.inData(periphData),
		.inReady(periphReady),
		.outValid(bufValid),
		.outData(bufData),
		.outReady(bufReady)
	);

	assign active = (state_r == ST_ACTIVE);
	assign bufReady = active & ramReady;
	assign ramValid = active & bufValid;
	assign xfer = ramValid & ramReady;

	// ********************************************************
	// Block counting and interrupt points
	// ********************************************************
	// Block length is count plus one, independent of size
	assign blockLen = {1'b0, transferCount} + DONE_ONE;
	// Rounds up so an odd length fires after the larger half
	assign halfPoint = ({1'b0, transferCount} + DONE_TWO) >> 1;
	assign doneNxt = doneCnt_r + DONE_ONE;
	assign lastXfer = (doneNxt == blockLen);
	// Half select is sampled live at every transfer
	assign halfHit = ctrl_r.halfSel && (doneNxt == halfPoint);
	assign irqEvent = xfer && (halfHit ||
		(!ctrl_r.halfSel && lastXfer));

	// Transfers done in the current block
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			doneCnt_r <= '0;
		end else if (!active) begin
			doneCnt_r <= '0;
		end else if (xfer) begin
			doneCnt_r <= lastXfer ? '0 : doneNxt;
		end
	end

	// ********************************************************
	// Channel sequencing
	// ********************************************************
	// One-shot stops after the block, or after buffer B in ping-pong
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_r <= ST_IDLE;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					if (ctrl_r.chanEnable) begin
						state_r <= ST_ACTIVE;
					end
				end
				ST_ACTIVE: begin
					if (!ctrl_r.chanEnable) begin
						state_r <= ST_IDLE;
					end else if (xfer && lastXfer && oneShot &&
						(!pingPong || bufB_r)) begin
						state_r <= ST_DONE;
					end
				end
				ST_DONE: begin
					if (!ctrl_r.chanEnable) begin
						state_r <= ST_IDLE;
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// Buffer select flips at each block end in ping-pong
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			bufB_r <= 1'b0;
		end else if (state_r == ST_IDLE) begin
			bufB_r <= 1'b0;
		end else if (xfer && lastXfer && pingPong) begin
			bufB_r <= ~bufB_r;
		end
	end

	assign channelBusy = active;
	assign activeBufferB = bufB_r;

	// ********************************************************
	// Address generation
	// ********************************************************
	assign startSel = bufB_r ? startAddressB : startAddressA;
	// First transfer of a block uses the start register directly
	assign curAddr = needLoad_r ? startSel : workAddr_r;
	assign step = ctrl_r.byteSize ? STEP_BYTE : STEP_WORD;

	// Reload request at channel start and at every block end
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			needLoad_r <= 1'b1;
		end else if (!active) begin
			needLoad_r <= 1'b1;
		end else if (xfer) begin
			needLoad_r <= lastXfer;
		end
	end

	// Working copy; the start registers are only ever read
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			workAddr_r <= '0;
		end else if (xfer) begin
			if (ctrl_r.addrMode == ADDRESSING_MODE_SELECT_POSTINC) begin
				workAddr_r <= curAddr + step;
			end else begin
				// Fixed mode holds the current location, which is the start after a block's first transfer
				workAddr_r <= curAddr;
			end
		end
	end

	// Latest transfer address for software readback
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			lastAddr_r <= '0;
		end else if (xfer) begin
			lastAddr_r <= curAddr;
		end
	end

	assign latestAddress = lastAddr_r;
	assign ramReq.addr = curAddr;
	assign ramReq.data = bufData;
	assign ramReq.byteSel = ctrl_r.byteSize;

	// ********************************************************
	// Interrupt flag
	// ********************************************************
	// A new event in the clearing cycle wins over the clear
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			flag_r <= 1'b0;
		end else if (irqEvent) begin
			flag_r <= 1'b1;
		end else if (flagClear) begin
			flag_r <= 1'b0;
		end
	end

	assign irqFlag = flag_r;
	// Reaches the processor only once software has enabled it
	assign irqRequest = flag_r & channelIrqEnable;

	// ********************************************************
	// Assertions
	// ********************************************************
	property p_half_fire;
		@(posedge core_clk) disable iff (rst)
		xfer && ctrl_r.halfSel && (doneCnt_r == halfPoint - DONE_ONE)
		|=> flag_r;
	endproperty
	a_half_fire: assert property (p_half_fire)
		else $error("no interrupt at half point");

	property p_no_end_fire;
		@(posedge core_clk) disable iff (rst)
		xfer && ctrl_r.halfSel && lastXfer && (halfPoint != blockLen)
		|-> !irqEvent;
	endproperty
	a_no_end_fire: assert property (p_no_end_fire)
		else $error("end interrupt raised with half select");

	property p_full_fire;
		@(posedge core_clk) disable iff (rst)
		xfer && !ctrl_r.halfSel && lastXfer |=> flag_r;
	endproperty
	a_full_fire: assert property (p_full_fire)
		else $error("no interrupt at block end");

	property p_full_only;
		@(posedge core_clk) disable iff (rst)
		!ctrl_r.halfSel && irqEvent |-> xfer && lastXfer;
	endproperty
	a_full_only: assert property (p_full_only)
		else $error("full mode interrupt before block end");

	property p_flag_hold;
		@(posedge core_clk) disable iff (rst)
		flag_r && !flagClear |=> flag_r;
	endproperty
	a_flag_hold: assert property (p_flag_hold)
		else $error("flag lost without clear");

	property p_set_wins;
		@(posedge core_clk) disable iff (rst)
		irqEvent && flagClear |=> flag_r ##1 (flag_r || $past(flagClear));
	endproperty
	a_set_wins: assert property (p_set_wins)
		else $error("clear beat simultaneous event");

	property p_reset_mode;
		@(posedge core_clk) disable iff (rst)
		!wrSeen_r |-> ctrl_r.addrMode == ADDRESSING_MODE_SELECT_POSTINC;
	endproperty
	a_reset_mode: assert property (p_reset_mode)
		else $error("addressing mode not post-increment after reset");

	property p_first_addr;
		@(posedge core_clk) disable iff (rst)
		xfer && (doneCnt_r == '0) |->
		ramReq.addr == (bufB_r ? startAddressB : startAddressA);
	endproperty
	a_first_addr: assert property (p_first_addr)
		else $error("block did not start at start address");

	property p_readback;
		@(posedge core_clk) disable iff (rst)
		xfer |=> latestAddress == $past(ramReq.addr);
	endproperty
	a_readback: assert property (p_readback)
		else $error("latest address not updated");

	property p_fixed;
		@(posedge core_clk) disable iff (rst)
		xfer && !lastXfer && (ctrl_r.addrMode == ADDRESSING_MODE_SELECT_FIXED) ##1
		xfer |-> ramReq.addr == $past(ramReq.addr);
	endproperty
	a_fixed: assert property (p_fixed)
		else $error("fixed mode address moved");

	property p_incr;
		@(posedge core_clk) disable iff (rst)
		xfer && !lastXfer && (ctrl_r.addrMode == ADDRESSING_MODE_SELECT_POSTINC) |=>
		workAddr_r == $past(curAddr) + ($past(ctrl_r.byteSize) ?
		STEP_BYTE : STEP_WORD);
	endproperty
	a_incr: assert property (p_incr)
		else $error("post-increment step wrong");

	property p_block_len;
		@(posedge core_clk) disable iff (rst)
		xfer && lastXfer |-> doneCnt_r == {1'b0, transferCount};
	endproperty
	a_block_len: assert property (p_block_len)
		else $error("block length not count plus one");

	property p_pingpong;
		@(posedge core_clk) disable iff (rst)
		xfer && lastXfer && (ctrl_r.opMode == MODE_OS_PP) && !bufB_r
		|=> bufB_r && active;
	endproperty
	a_pingpong: assert property (p_pingpong)
		else $error("ping-pong did not move to buffer B");

endmodule : dma_channel_addr_irq

// file: shared/dma_chan_pkg.sv
// Shared types and constants for the DMA channel address and interrupt block
package dma_chan_pkg;

	// ********************************************************
	// Widths
	// ********************************************************
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam int CNT_W = 14;
	localparam int DONE_W = CNT_W + 1;
	localparam int BUF_DEPTH = 2;

	// ********************************************************
	// Field encodings
	// ********************************************************
	// Addressing mode select
	localparam logic [1:0] ADDRESSING_MODE_SELECT_POSTINC = 2'h0;
	localparam logic [1:0] ADDRESSING_MODE_SELECT_FIXED = 2'h1;
	// Operating mode field: bit 0 one-shot, bit 1 ping-pong
	localparam logic [1:0] MODE_CONT = 2'h0;
	localparam logic [1:0] MODE_OS_PP = 2'h3;
	localparam int MODE_ONESHOT_BIT = 0;
	localparam int MODE_PINGPONG_BIT = 1;

	// Address steps after a transfer, and block count increments
	localparam logic [ADDR_W-1:0] STEP_WORD = 16'h0002;
	localparam logic [ADDR_W-1:0] STEP_BYTE = 16'h0001;
	localparam logic [DONE_W-1:0] DONE_ONE = 15'h0001;
	localparam logic [DONE_W-1:0] DONE_TWO = 15'h0002;

	// ********************************************************
	// Types
	// ********************************************************
	typedef struct packed {
		logic chanEnable;
		logic byteSize;
		logic halfSel;
		logic [1:0] addrMode;
		logic [1:0] opMode;
	} ctrl_type;

	localparam ctrl_type CTRL_RESET = '{1'b0, 1'b0, 1'b0,
		ADDRESSING_MODE_SELECT_POSTINC, MODE_CONT};

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic byteSel;
	} ram_req_type;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_ACTIVE = 2'h1,
		ST_DONE = 2'h3
	} chan_state_type;

endpackage : dma_chan_pkg

// file: hw/two_entry_buffer.sv
// Small flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
module two_entry_buffer #(
	parameter int WIDTH = dma_chan_pkg::DATA_W,
	parameter int DEPTH = dma_chan_pkg::BUF_DEPTH
) (
	// Clock and reset
	input logic core_clk,
	input logic rst,
	// Filling side
	input logic inValid,
	input logic [WIDTH-1:0] inData,
	output logic inReady,
	// Draining side
	output logic outValid,
	output logic [WIDTH-1:0] outData,
	input logic outReady
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [PW-1:0] LAST_IDX = PW'(DEPTH - 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [PW-1:0] wrPtr_r;
	logic [PW-1:0] rdPtr_r;
	logic [CW-1:0] fill_r;
	logic push;
	logic pop;

	// Full and empty come straight from the fill count
	assign inReady = (fill_r != FULL_CNT);
	assign outValid = (fill_r != '0);
	assign outData = mem_r[rdPtr_r];
	assign push = inValid & inReady;
	assign pop = outValid & outReady;

	// Storage needs no reset; fill count guards stale entries
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem_r[wrPtr_r] <= inData;
		end
	end

	// Pointers and fill level
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			fill_r <= '0;
		end else begin
			if (push) begin
				wrPtr_r <= (wrPtr_r == LAST_IDX) ? '0 : wrPtr_r + 1'b1;
			end
			if (pop) begin
				rdPtr_r <= (rdPtr_r == LAST_IDX) ? '0 : rdPtr_r + 1'b1;
			end
			if (push && !pop) begin
				fill_r <= fill_r + 1'b1;
			end else if (pop && !push) begin
				fill_r <= fill_r - 1'b1;
			end
		end
	end

endmodule : two_entry_buffer

// file: tb/ram_sink.sv
// Behavioural RAM write port that paces and logs channel writes
`timescale 1ns/1ps
module ram_sink (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Pacing chosen by the bench
	input wire logic slow,
	input wire logic hold,
	// Write port
	input wire logic ramValid,
	input wire dma_chan_pkg::ram_req_type ramReq,
	output logic ramReady,
	// Number of accepted writes
	output int takenCount
);
	import dma_chan_pkg::*;

	logic toggle_r;
	logic [ADDR_W-1:0] logAddr [0:63];
	logic [DATA_W-1:0] logData [0:63];

	// Slow pacing refuses every other cycle, so the channel must hold
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			toggle_r <= 1'b0;
		end else begin
			toggle_r <= ~toggle_r;
		end
	end

	assign ramReady = ~hold & (~slow | toggle_r);

	// Log each write on the edge that accepts it
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			takenCount <= 0;
		end else if (ramValid && ramReady) begin
			logAddr[takenCount[5:0]] <= ramReq.addr;
			logData[takenCount[5:0]] <= ramReq.data;
			takenCount <= takenCount + 1;
		end
	end
endmodule : ram_sink

// file: tb/dma_channel_addr_irq_tb.sv
// Self-checking bench for the DMA channel address and interrupt block
`timescale 1ns/1ps
module dma_channel_addr_irq_tb;
	import dma_chan_pkg::*;

	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic ctrlWrite = 1'b0;
	ctrl_type ctrlIn = CTRL_RESET;
	ctrl_type ctrlOut;
	logic [CNT_W-1:0] transferCount = '0;
	logic [ADDR_W-1:0] startA = '0;
	logic [ADDR_W-1:0] startB = '0;
	logic [ADDR_W-1:0] latestAddress;
	logic channelBusy, activeBufferB, irqFlag, irqRequest;
	logic flagClear = 1'b0;
	logic irqEn = 1'b0;
	logic periphValid = 1'b0;
	logic [DATA_W-1:0] periphData = '0;
	logic periphReady, ramValid, ramReady;
	ram_req_type ramReq;
	logic slow = 1'b0;
	logic hold = 1'b0;
	int takenCount;
	int miscompares = 0;
	int checked = 0;
	int nExp = 0;
	int base;
	logic [DATA_W-1:0] seqData = 16'ha500;

	// ********************************************************
	// Clock, design and far side
	// ********************************************************
	always #12.5 core_clk = ~core_clk;

	dma_channel_addr_irq dma_channel_addr_irq_inst (.core_clk(core_clk),
		.rst(rst), .ctrlWrite(ctrlWrite), .ctrlIn(ctrlIn),
		.ctrlOut(ctrlOut), .transferCount(transferCount),
		.startAddressA(startA), .startAddressB(startB),
		.latestAddress(latestAddress), .channelBusy(channelBusy),
		.activeBufferB(activeBufferB), .flagClear(flagClear),
		.channelIrqEnable(irqEn), .irqFlag(irqFlag),
		.irqRequest(irqRequest), .periphValid(periphValid),
		.periphData(periphData), .periphReady(periphReady),
		.ramValid(ramValid), .ramReady(ramReady), .ramReq(ramReq));

	ram_sink ram_sink_inst (.core_clk(core_clk), .rst(rst), .slow(slow),
		.hold(hold), .ramValid(ramValid), .ramReq(ramReq),
		.ramReady(ramReady), .takenCount(takenCount));

	// ********************************************************
	// Compare, access and closing tasks
	// ********************************************************
	task automatic report_and_stop();
		if (miscompares == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : report_and_stop

	task automatic chkBit(string what, logic exp, logic got);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %b seen %b", what, exp, got);
		end
	endtask : chkBit

	task automatic chkWord(string what, logic [15:0] exp, logic [15:0] got);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chkWord

	// A wait that runs out ends the run as a mismatch
	task automatic timeout();
		miscompares++;
		report_and_stop();
	endtask : timeout

	task automatic setCtrl(ctrl_type c);
		ctrlWrite = 1'b1;
		ctrlIn = c;
		@(negedge core_clk);
		ctrlWrite = 1'b0;
		chkWord("ctrlOut", 16'(c), 16'(ctrlOut));
	endtask : setCtrl

	// Disable first so the block restarts from start A
	task automatic start(logic bs, logic hs, logic [1:0] am, logic [1:0] om,
		logic [CNT_W-1:0] cnt, logic [15:0] a, logic [15:0] b);
		setCtrl('{1'b0, bs, hs, am, om});
		transferCount = cnt;
		startA = a;
		startB = b;
		// An edge passes so ctrlWrite falls before it rises again
		@(negedge core_clk);
		setCtrl('{1'b1, bs, hs, am, om});
		base = nExp;
	endtask : start

	// Words are held valid until a negedge shows ready
	task automatic push(int n);
		int i;
		for (int k = 0; k < n; k++) begin
			periphData = seqData;
			periphValid = 1'b1;
			for (i = 0; i < 100 && periphReady !== 1'b1; i++) @(negedge core_clk);
			if (periphReady !== 1'b1) timeout();
			@(negedge core_clk);
			seqData = seqData + 16'h0001;
		end
		periphValid = 1'b0;
	endtask : push

	task automatic waitTaken();
		for (int i = 0; i < 200 && takenCount != nExp; i++) @(negedge core_clk);
		if (takenCount != nExp) timeout();
	endtask : waitTaken

	task automatic xfer(int n, logic expFlag);
		push(n);
		nExp += n;
		waitTaken();
		chkBit("irqFlag", expFlag, irqFlag);
	endtask : xfer

	task automatic clr();
		flagClear = 1'b1;
		@(negedge core_clk);
		flagClear = 1'b0;
		chkBit("irqFlag", 1'b0, irqFlag);
	endtask : clr

	task automatic chkLog(int idx, logic [15:0] exp);
		chkWord("ramAddr", exp, ram_sink_inst.logAddr[idx]);
	endtask : chkLog

	// ********************************************************
	// Scenarios
	// ********************************************************
	initial begin
		repeat (5) @(posedge core_clk);
		@(negedge core_clk);
		rst = 1'b0;
		chkWord("ctrlOut", 16'(CTRL_RESET), 16'(ctrlOut));
		chkBit("periphReady", 1'b1, periphReady);
		// Word one-shot with a stalled RAM filling the buffer
		start(1'b0, 1'b0, ADDRESSING_MODE_SELECT_POSTINC, 2'h1, 14'h0003, 16'h0100, 16'h0200);
		hold = 1'b1;
		push(2);
		chkBit("periphReady", 1'b0, periphReady);
		hold = 1'b0;
		slow = 1'b1;
		nExp = 2;
		waitTaken();
		chkBit("irqFlag", 1'b0, irqFlag);
		xfer(2, 1'b1);
		slow = 1'b0;
		for (int i = 0; i < 4; i++) chkLog(i, 16'h0100 + 16'(2 * i));
		chkWord("latestAddress", 16'h0106, latestAddress);
		chkWord("ramData", 16'ha503, ram_sink_inst.logData[3]);
		chkBit("byteSel", 1'b0, ramReq.byteSel);
		chkBit("channelBusy", 1'b0, channelBusy);
		chkBit("irqRequest", 1'b0, irqRequest);
		irqEn = 1'b1;
		repeat (3) @(negedge core_clk);
		chkBit("irqFlag", 1'b1, irqFlag);
		chkBit("irqRequest", 1'b1, irqRequest);
		clr();
		// One-shot ping-pong, half point of an odd block of seven
		start(1'b0, 1'b1, ADDRESSING_MODE_SELECT_POSTINC, MODE_OS_PP, 14'h0006, 16'h0200,
			16'h0300);
		for (int b = 0; b < 2; b++) begin
			xfer(3, 1'b0);
			xfer(1, 1'b1);
			clr();
			xfer(3, 1'b0);
			chkLog(base + 7 * b, b ? 16'h0300 : 16'h0200);
			chkBit("activeBufferB", b == 0, activeBufferB);
		end
		chkBit("channelBusy", 1'b0, channelBusy);
		// Byte ping-pong, half select dropped and fixed mode mid-block
		start(1'b1, 1'b1, ADDRESSING_MODE_SELECT_POSTINC, 2'h2, 14'h0003, 16'h0400,
			16'h0500);
		xfer(2, 1'b1);
		chkLog(base + 1, 16'h0401);
		chkBit("byteSel", 1'b1, ramReq.byteSel);
		clr();
		setCtrl('{1'b1, 1'b1, 1'b0, ADDRESSING_MODE_SELECT_FIXED, 2'h2});
		xfer(2, 1'b1);
		chkLog(base + 2, 16'h0402);
		chkLog(base + 3, 16'h0402);
		clr();
		setCtrl('{1'b1, 1'b1, 1'b0, ADDRESSING_MODE_SELECT_POSTINC, 2'h2});
		xfer(4, 1'b1);
		chkLog(base + 4, 16'h0500);
		chkLog(base + 7, 16'h0503);
		clr();
		// Single-element blocks back to back
		start(1'b0, 1'b0, ADDRESSING_MODE_SELECT_POSTINC, MODE_CONT, 14'h0000, 16'h0600,
			16'h0700);
		xfer(1, 1'b1);
		// Clear held on the edge of the next event: the set must win
		push(1);
		flagClear = 1'b1;
		@(negedge core_clk);
		flagClear = 1'b0;
		nExp += 1;
		waitTaken();
		chkBit("irqFlag", 1'b1, irqFlag);
		@(negedge core_clk);
		clr();
		xfer(1, 1'b1);
		chkLog(base + 1, 16'h0600);
		chkLog(base + 2, 16'h0600);
		report_and_stop();
	end
endmodule : dma_channel_addr_irq_tb
